// *** pkg/cbo_pkg.sv ***
// constants, types and register map of the capacitor overload pickup stage
package cbo_pkg;
    // ==================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int STAMP_RES_NS = 1000000;
    localparam int CYC_PER_MS = (STAMP_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_MS = 5;
    localparam int PREFAULT_MS = 20;
    localparam int PREFAULT_N = PREFAULT_MS / CYCLE_MS;
    localparam int HIST_N = 2 * PREFAULT_N;
    // ==================================================
    // pickup
    localparam int RESET_RATIO_PCT = 97;
    localparam int FULL_PCT = 100;
    localparam int NUM_PH = 3;
    localparam int NUM_SETS = 8;
    localparam int TRMS_HARMONICS = 32;
    // ==================================================
    // register offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_CNT_START = 8'h08;
    localparam logic [7:0] ADR_CNT_TRIP = 8'h0c;
    localparam logic [7:0] ADR_CNT_BLK = 8'h10;
    localparam logic [7:0] ADR_PREFAULT = 8'h14;
    localparam logic [7:0] ADR_STAMP = 8'h18;
    localparam logic [7:0] ADR_SET0 = 8'h20;
    localparam logic [7:0] ADR_SET_STEP = 8'h04;
    // ctrl fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_FORCE_LSB = 2;
    localparam int CTRL_CLR_BIT = 8;
    // ==================================================
    // enumerations
    typedef enum logic [1:0] {
        MAG_RMS = 2'h1,
        MAG_TRMS = 2'h2,
        MAG_PP = 2'h3
    } cbo_mag_e;
    typedef enum logic [2:0] {
        FRC_NORMAL = 3'h1,
        FRC_START = 3'h2,
        FRC_TRIP = 3'h3,
        FRC_BLOCKED = 3'h4
    } cbo_force_e;
    typedef enum logic [1:0] {
        MODE_INSTANT = 2'h0,
        MODE_DT = 2'h1,
        MODE_IDMT = 2'h2
    } cbo_mode_e;
    // ==================================================
    // carriers
    typedef struct packed {
        logic [15:0] delay_ms;
        logic rsv;
        cbo_mode_e mode;
        logic [12:0] thr;
    } cbo_set_s;
    typedef struct packed {
        logic blk_off;
        logic blk_on;
        logic trip_off;
        logic trip_on;
        logic start_off;
        logic start_on;
        logic [31:0] stamp;
    } cbo_evt_s;
    // ==================================================
    // reset values
    localparam logic [12:0] THR_RST = 13'h0078;
    localparam logic [15:0] DELAY_RST = 16'h03e8;
    localparam cbo_set_s SET_RST = '{DELAY_RST, 1'b0, MODE_DT, THR_RST};
    localparam cbo_mag_e MAG_RST = MAG_RMS;
    localparam cbo_force_e FORCE_RST = FRC_NORMAL;
endpackage

// *** design/cbo_overload.sv ***
// three-phase capacitor bank overload pickup, timing, events and counters
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// RULE1: each phase compared separately, any phase picks
// RULE2: release below 97 percent of threshold
// RULE3: one shared threshold, 0.01 steps, 1.20 default
// RULE4: selector 1 rms, 2 trms, 3 peak-peak
// RULE5: true rms covers harmonics up to 32nd
// RULE6: peak-peak taken from sample-based channel
// RULE7: nine magnitudes refreshed every 5 ms
// RULE8: prefault is 20 ms average, 20 ms back
// RULE9: start only while blocking inactive
// RULE10: on/off events for start, trip, blocked
// RULE11: instant mode start and trip share stamp
// RULE12: event stamps have 1 ms resolution
// RULE13: clearable start, trip, blocked counters
// RULE14: eight parameter sets, one shared selector
// RULE15: instant, definite time or inverse time modes
// RULE16: status forcing 1..4, needs global enable
// RULE17: block and set changes apply live
// RULE18: saturation flagged, operation continues
// RULE19: block sampled each cycle, blocked halts event
// RULE20: partner presents block 5 ms ahead; the bench model sends it with the levels
// RULE21: delayed trip when timer completes unblocked
module cbo_overload #(
    parameter int CYC_PER_MS = cbo_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // measurement channels, units of 0.01 nominal
    input wire logic [15:0] phase_a_fund_rms,
    input wire logic [15:0] phase_b_fund_rms,
    input wire logic [15:0] phase_c_fund_rms,
    input wire logic [15:0] phase_a_true_rms,
    input wire logic [15:0] phase_b_true_rms,
    input wire logic [15:0] phase_c_true_rms,
    input wire logic [15:0] phase_a_peak_peak,
    input wire logic [15:0] phase_b_peak_peak,
    input wire logic [15:0] phase_c_peak_peak,
    input wire logic [2:0] ct_saturated,
    // control from system logic
    input wire logic block_in,
    input wire logic [2:0] set_select,
    input wire logic force_enable,
    // outputs
    output logic start,
    output logic trip,
    output logic blocked,
    output logic evt_valid,
    output cbo_pkg::cbo_evt_s evt
);
    // ==================================================
    // reset release
    logic [1:0] rst_pipe;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rst_pipe <= 2'h0;
        else rst_pipe <= {rst_pipe[0], 1'b1};
    end
    wire rst_sync_n = rst_pipe[1];

    // ==================================================
    // time base
    logic [16:0] ms_cnt;
    logic ms_tick;
    logic [2:0] step_cnt;
    logic tick5;
    logic proc;
    logic proc2;
    logic [31:0] stamp;
    wire ms_wrap = (ms_cnt == 17'(CYC_PER_MS - 1));
    wire step_wrap = (step_cnt == 3'(cbo_pkg::CYCLE_MS - 1));
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ms_cnt <= 17'h0;
            ms_tick <= 1'b0;
            step_cnt <= 3'h0;
            tick5 <= 1'b0;
            proc <= 1'b0;
            proc2 <= 1'b0;
            stamp <= 32'h0;
        end else begin
            ms_cnt <= ms_wrap ? 17'h0 : ms_cnt + 17'h1;
            ms_tick <= ms_wrap;
            tick5 <= ms_tick && step_wrap; // RULE7
            proc <= tick5;
            proc2 <= proc;
            if (ms_tick) begin
                stamp <= stamp + 32'h1; // RULE12
                step_cnt <= step_wrap ? 3'h0 : step_cnt + 3'h1;
            end
        end
    end

    // ==================================================
    // registers
    cbo_pkg::cbo_mag_e mag_sel;
    cbo_pkg::cbo_force_e force_sel;
    cbo_pkg::cbo_set_s sets [cbo_pkg::NUM_SETS];
    wire wr_ctrl = reg_wr && (reg_addr == cbo_pkg::ADR_CTRL);
    wire clr_cnt = wr_ctrl && reg_wdata[cbo_pkg::CTRL_CLR_BIT];
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mag_sel <= cbo_pkg::MAG_RST; // RULE4
            force_sel <= cbo_pkg::FORCE_RST; // RULE16
        end else if (wr_ctrl) begin
            mag_sel <= cbo_pkg::cbo_mag_e'(reg_wdata[cbo_pkg::CTRL_SEL_LSB +: 2]);
            force_sel <= cbo_pkg::cbo_force_e'(reg_wdata[cbo_pkg::CTRL_FORCE_LSB +: 3]);
        end
    end
    genvar k;
    generate
        for (k = 0; k < cbo_pkg::NUM_SETS; k++) begin : g_set
            wire [7:0] set_adr = 8'(cbo_pkg::ADR_SET0 + k * cbo_pkg::ADR_SET_STEP);
            always_ff @(posedge clk or negedge rst_sync_n) begin
                if (!rst_sync_n) sets[k] <= cbo_pkg::SET_RST; // RULE3
                else if (reg_wr && reg_addr == set_adr) sets[k] <= reg_wdata; // RULE14
            end
        end
    endgenerate

    // ==================================================
    // per-cycle sampling
    // block, set and magnitudes are caught together so one cycle sees one view
    wire [15:0] fund [cbo_pkg::NUM_PH];
    wire [15:0] trms [cbo_pkg::NUM_PH];
    wire [15:0] ppk [cbo_pkg::NUM_PH];
    assign fund[0] = phase_a_fund_rms;
    assign fund[1] = phase_b_fund_rms;
    assign fund[2] = phase_c_fund_rms;
    assign trms[0] = phase_a_true_rms; // RULE5
    assign trms[1] = phase_b_true_rms;
    assign trms[2] = phase_c_true_rms;
    assign ppk[0] = phase_a_peak_peak; // RULE6
    assign ppk[1] = phase_b_peak_peak;
    assign ppk[2] = phase_c_peak_peak;
    logic [15:0] mag_q [cbo_pkg::NUM_PH];
    logic blk_q;
    logic [2:0] sat_q;
    cbo_pkg::cbo_set_s set_q;
    logic [2:0] pick;
    wire [12:0] thr = set_q.thr;
    genvar p;
    generate
        for (p = 0; p < cbo_pkg::NUM_PH; p++) begin : g_ph
            wire [15:0] sel = (mag_sel == cbo_pkg::MAG_TRMS) ? trms[p] :
                              (mag_sel == cbo_pkg::MAG_PP) ? ppk[p] : fund[p]; // RULE4
            wire [23:0] scaled = 24'(mag_q[p] * 7'(cbo_pkg::FULL_PCT));
            wire [23:0] limit = 24'(thr * 7'(cbo_pkg::RESET_RATIO_PCT));
            wire over = mag_q[p] > {3'h0, thr}; // RULE1
            wire under = scaled < limit; // RULE2
            wire next_pick = over || (pick[p] && !under);
            always_ff @(posedge clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    mag_q[p] <= 16'h0;
                    pick[p] <= 1'b0;
                end else begin
                    if (tick5) mag_q[p] <= sel; // RULE7
                    if (proc) pick[p] <= next_pick; // RULE1 RULE2
                end
            end
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            blk_q <= 1'b0;
            sat_q <= 3'h0;
            set_q <= cbo_pkg::SET_RST;
        end else if (tick5) begin
            blk_q <= block_in; // RULE19 RULE17
            sat_q <= ct_saturated; // RULE18
            set_q <= sets[set_select]; // RULE14 RULE17
        end
    end

    // ==================================================
    // highest phase and prefault history
    wire [15:0] max_ab = (mag_q[0] > mag_q[1]) ? mag_q[0] : mag_q[1];
    wire [15:0] max_mag = (max_ab > mag_q[2]) ? max_ab : mag_q[2];
    logic [15:0] hist [cbo_pkg::HIST_N];
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < cbo_pkg::HIST_N; i++) hist[i] <= 16'h0;
        end else if (proc) begin
            hist[0] <= max_mag;
            for (int i = 1; i < cbo_pkg::HIST_N; i++) hist[i] <= hist[i - 1];
        end
    end
    // oldest four entries span 20..40 ms before the decision
    wire [17:0] old_sum = 18'(hist[4]) + 18'(hist[5]) + 18'(hist[6]) + 18'(hist[7]);
    wire [15:0] old_avg = old_sum[17:2]; // RULE8

    // ==================================================
    // operating time
    // dt adds 5 x thr per step, idmt adds 5 x highest measured: time scales as thr/measured
    logic [31:0] acc;
    wire delayed = set_q.mode != cbo_pkg::MODE_INSTANT;
    wire [15:0] step_val = (set_q.mode == cbo_pkg::MODE_IDMT) ? max_mag : {3'h0, thr};
    wire [31:0] inc = 32'(step_val * 3'(cbo_pkg::CYCLE_MS));
    wire [31:0] target = 32'(set_q.delay_ms * thr);
    wire [32:0] acc_sum = 33'(acc) + 33'(inc);
    wire any_pick = |pick;
    wire raw_start = any_pick && !blk_q; // RULE9
    wire raw_blk = any_pick && blk_q; // RULE19
    wire time_done = acc_sum >= 33'(target);
    wire raw_trip = delayed ? (raw_start && (trip || time_done)) : raw_start; // RULE21 RULE15
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) acc <= 32'h0;
        else if (proc2) begin
            if (!raw_start) acc <= 32'h0;
            else if (!time_done) acc <= acc_sum[31:0]; // RULE15
        end
    end

    // ==================================================
    // forcing and outputs
    wire force_act = force_enable && (force_sel != cbo_pkg::FRC_NORMAL); // RULE16
    wire f_trip = force_sel == cbo_pkg::FRC_TRIP;
    wire f_start = (force_sel == cbo_pkg::FRC_START) || f_trip;
    wire f_blk = force_sel == cbo_pkg::FRC_BLOCKED;
    wire next_start = force_act ? f_start : raw_start; // RULE16
    wire next_trip = force_act ? f_trip : raw_trip;
    wire next_blocked = force_act ? f_blk : raw_blk;
    wire s_on = next_start && !start;
    wire s_off = !next_start && start;
    wire t_on = next_trip && !trip;
    wire t_off = !next_trip && trip;
    wire b_on = next_blocked && !blocked;
    wire b_off = !next_blocked && blocked;
    wire any_evt = s_on || s_off || t_on || t_off || b_on || b_off;
    logic [15:0] prefault;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            start <= 1'b0;
            trip <= 1'b0;
            blocked <= 1'b0;
            evt_valid <= 1'b0;
            evt <= '0;
            prefault <= 16'h0;
        end else begin
            evt_valid <= proc2 && any_evt; // RULE10
            if (proc2) begin
                start <= next_start;
                trip <= next_trip;
                blocked <= next_blocked;
                // one record, one stamp: simultaneous edges share it
                evt <= '{b_off, b_on, t_off, t_on, s_off, s_on, stamp}; // RULE10 RULE11
                if (s_on || t_on) prefault <= old_avg; // RULE8
            end
        end
    end

    // ==================================================
    // counters, a clear with an increment in the same cycle leaves 1
    logic [31:0] cnt_start;
    logic [31:0] cnt_trip;
    logic [31:0] cnt_blk;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt_start <= 32'h0;
            cnt_trip <= 32'h0;
            cnt_blk <= 32'h0;
        end else begin
            if (proc2 && s_on) cnt_start <= clr_cnt ? 32'h1 : cnt_start + 32'h1; // RULE13
            else if (clr_cnt) cnt_start <= 32'h0;
            if (proc2 && t_on) cnt_trip <= clr_cnt ? 32'h1 : cnt_trip + 32'h1;
            else if (clr_cnt) cnt_trip <= 32'h0;
            if (proc2 && b_on) cnt_blk <= clr_cnt ? 32'h1 : cnt_blk + 32'h1;
            else if (clr_cnt) cnt_blk <= 32'h0;
        end
    end

    // ==================================================
    // read port
    wire [31:0] ctrl_val = {27'h0, force_sel, mag_sel};
    wire [31:0] status_val = {20'h0, set_select, sat_q, pick, blocked, trip, start};
    wire [31:0] set_off = 32'(reg_addr - cbo_pkg::ADR_SET0);
    wire in_sets = (reg_addr >= cbo_pkg::ADR_SET0) && (set_off[31:2] < cbo_pkg::NUM_SETS);
    wire [31:0] set_val = sets[set_off[4:2]];
    wire [31:0] next_rdata = !reg_rd ? 32'h0 :
        (reg_addr == cbo_pkg::ADR_CTRL) ? ctrl_val :
        (reg_addr == cbo_pkg::ADR_STATUS) ? status_val :
        (reg_addr == cbo_pkg::ADR_CNT_START) ? cnt_start :
        (reg_addr == cbo_pkg::ADR_CNT_TRIP) ? cnt_trip :
        (reg_addr == cbo_pkg::ADR_CNT_BLK) ? cnt_blk :
        (reg_addr == cbo_pkg::ADR_PREFAULT) ? {16'h0, prefault} :
        (reg_addr == cbo_pkg::ADR_STAMP) ? stamp :
        (in_sets && reg_addr[1:0] == 2'h0) ? set_val : 32'h0;
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) reg_rdata <= 32'h0;
        else reg_rdata <= next_rdata;
    end

    // ==================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    property p_pick_on;
        proc && (mag_q[0] > {3'h0, thr}) |=> pick[0];
    endproperty
    a_pick_on: assert property (p_pick_on) else $error("phase over threshold not picked"); // RULE1

    property p_hyst_hold;
        proc && pick[1] && (32'(mag_q[1]) * 100 >= 32'(thr) * 97) |=> pick[1];
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("pickup dropped above 97 pct"); // RULE2

    property p_sel_fund;
        tick5 && mag_sel == cbo_pkg::MAG_RMS |=> mag_q[2] == $past(phase_c_fund_rms);
    endproperty
    a_sel_fund: assert property (p_sel_fund) else $error("rms selection not used"); // RULE4

    property p_block_start;
        proc2 && !force_act && blk_q |=> !start && (blocked == $past(any_pick));
    endproperty
    a_block_start: assert property (p_block_start) else $error("start while blocked"); // RULE9

    property p_instant_pair;
        evt_valid && evt.start_on && !delayed && !force_act |-> evt.trip_on;
    endproperty
    a_instant_pair: assert property (p_instant_pair) else $error("instant trip not paired"); // RULE11

    property p_stamp_step;
        ms_tick |=> stamp == $past(stamp) + 32'h1;
    endproperty
    a_stamp_step: assert property (p_stamp_step) else $error("stamp not 1 ms step"); // RULE12

    property p_cnt_inc;
        proc2 && s_on && !clr_cnt |=> cnt_start == $past(cnt_start) + 32'h1;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("start counter missed"); // RULE13

    property p_force_trip;
        proc2 && force_enable && force_sel == cbo_pkg::FRC_TRIP |=> trip && start;
    endproperty
    a_force_trip: assert property (p_force_trip) else $error("forced trip ignored"); // RULE16

    property p_dt_trip;
        $rose(trip) && delayed && !$past(force_act) |-> $past(time_done) && !$past(blk_q);
    endproperty
    a_dt_trip: assert property (p_dt_trip) else $error("delayed trip early"); // RULE21

    c_block: cover property (proc2 && raw_blk ##1 blocked);
    c_instant: cover property (evt_valid && evt.start_on && evt.trip_on);
    c_delayed: cover property (start && !trip ##1 start [*3] ##1 trip);
endmodule

// *** sim/cbo_meas_model.sv ***
// measurement channel and blocking source model for the overload stage
`timescale 1ns/1ps
module cbo_meas_model #(
    parameter int CYC_PER_MS = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requests from the bench
    input wire logic [2:0][15:0] lvl,
    input wire logic [2:0] kind,
    input wire logic blk_req,
    // channels towards the stage
    output logic [2:0][15:0] fund,
    output logic [2:0][15:0] trms,
    output logic [2:0][15:0] ppk,
    output logic block_out
);
    // ==================================================
    // refresh on the 5 ms measurement base
    // requests between refreshes wait, so block arrives with the levels, one base late at worst
    localparam int PER = 5 * CYC_PER_MS;
    int cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            fund <= '0;
            trms <= '0;
            ppk <= '0;
            block_out <= 1'b0;
        end else begin
            cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
            if (cnt == 0) begin
                fund <= kind[0] ? lvl : '0;
                trms <= kind[1] ? lvl : '0;
                ppk <= kind[2] ? lvl : '0;
                block_out <= blk_req;
            end
        end
    end
endmodule

// *** sim/tb.sv ***
// self-checking bench of the capacitor overload pickup stage
`timescale 1ns/1ps
module tb;
    // ==================================================
    // signals
    localparam int CPM = 10;
    localparam int DEC = 5 * CPM;
    logic clk;
    logic rst_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [2:0][15:0] lvl;
    logic [2:0] kind;
    logic blk_req;
    logic [2:0][15:0] fund;
    logic [2:0][15:0] trms;
    logic [2:0][15:0] ppk;
    logic block_in;
    logic [2:0] set_select;
    logic force_enable;
    logic [2:0] ct_saturated;
    logic start;
    logic trip;
    logic blocked;
    logic evt_valid;
    cbo_pkg::cbo_evt_s evt;
    cbo_pkg::cbo_evt_s e;
    logic [31:0] d0;
    logic [31:0] d1;
    logic [2:0] fx [3];
    int num_errors;
    int n_compared;
    int cyc = 0;
    int t0;
    cbo_meas_model #(.CYC_PER_MS(CPM)) i_meas (.clk(clk), .rst_n(rst_n), .lvl(lvl), .kind(kind),
        .blk_req(blk_req), .fund(fund), .trms(trms), .ppk(ppk), .block_out(block_in));
    cbo_overload #(.CYC_PER_MS(CPM)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .phase_a_fund_rms(fund[0]), .phase_b_fund_rms(fund[1]), .phase_c_fund_rms(fund[2]),
        .phase_a_true_rms(trms[0]), .phase_b_true_rms(trms[1]), .phase_c_true_rms(trms[2]),
        .phase_a_peak_peak(ppk[0]), .phase_b_peak_peak(ppk[1]), .phase_c_peak_peak(ppk[2]),
        .ct_saturated(ct_saturated), .block_in(block_in), .set_select(set_select),
        .force_enable(force_enable), .start(start), .trip(trip), .blocked(blocked),
        .evt_valid(evt_valid), .evt(evt));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // ==================================================
    // tasks
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic chk_reg(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask
    task automatic outs(input string name, input logic [2:0] exp);
        check(name, {29'h0, blocked, trip, start}, {29'h0, exp});
    endtask
    // no-event waits span whole decisions, the stage acts once per 5 ms
    task automatic idle(input int n);
        repeat (n * DEC) @(posedge clk);
    endtask
    task automatic wait_evt();
        for (int i = 0; i < 4 * DEC; i++) begin
            @(posedge clk);
            #1;
            if (evt_valid === 1'b1) begin
                e = evt;
                return;
            end
        end
        num_errors++;
        $display("[FAIL] event pulse expected 1 seen 0");
        report_and_stop();
    endtask
    task automatic apply(input logic [15:0] v, input logic [2:0] m, input logic [2:0] k,
            input logic b);
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            lvl[i] <= m[i] ? v : 16'h0;
        end
        kind <= k;
        blk_req <= b;
    endtask
    // ==================================================
    // main sequence
    initial begin
        fx = '{3'b001, 3'b011, 3'b100};
        {reg_addr, reg_wdata, reg_wr, reg_rd, lvl, blk_req, set_select, force_enable} = '0;
        kind = 3'h1;
        ct_saturated = 3'h5;
        num_errors = 0;
        n_compared = 0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        outs("outputs after reset", 3'b000);
        chk_reg("ctrl reset", cbo_pkg::ADR_CTRL, 32'h0000_0005);
        chk_reg("set0 reset", cbo_pkg::ADR_SET0, 32'h03e8_2078);
        chk_reg("set7 reset", cbo_pkg::ADR_SET0 + 8'h1c, 32'h03e8_2078);
        wr(8'h1c, 32'hffff_ffff);
        chk_reg("unmapped", 8'h1c, 32'h0);
        wr(cbo_pkg::ADR_SET0, 32'h0014_0078);
        for (int p = 0; p < 3; p++) begin
            apply(16'h0079, 3'h1 << p, 3'h1, 1'b0);
            wait_evt();
            outs("instant pick", 3'b011);
            check("start trip on", {30'h0, e.start_on, e.trip_on}, 32'h3);
            apply(16'h0075, 3'h1 << p, 3'h1, 1'b0);
            idle(3);
            outs("hold above ratio", 3'b011);
            apply(16'h0074, 3'h1 << p, 3'h1, 1'b0);
            wait_evt();
            outs("release", 3'b000);
            check("off events", {30'h0, e.start_off, e.trip_off}, 32'h3);
        end
        apply(16'h0078, 3'h7, 3'h1, 1'b0);
        idle(3);
        outs("equal threshold", 3'b000);
        for (int k = 1; k <= 3; k++) begin
            wr(cbo_pkg::ADR_CTRL, 32'(k) | 32'h4);
            apply(16'h0082, 3'h7, 3'h1 << (k - 1), 1'b0);
            wait_evt();
            outs("selected magnitude", 3'b011);
            apply(16'h0082, 3'h7, ~(3'h1 << (k - 1)), 1'b0);
            wait_evt();
            outs("unselected magnitude", 3'b000);
        end
        // levels settle before rms is reselected, else the stale 1.30 level picks
        apply(16'h0064, 3'h7, 3'h1, 1'b1);
        idle(1);
        wr(cbo_pkg::ADR_CTRL, 32'h105);
        idle(9);
        apply(16'h0082, 3'h7, 3'h1, 1'b1);
        wait_evt();
        outs("blocked pick", 3'b100);
        check("blocked on event", {31'h0, e.blk_on}, 32'h1);
        apply(16'h0082, 3'h7, 3'h1, 1'b0);
        wait_evt();
        outs("block removed live", 3'b011);
        chk_reg("prefault", cbo_pkg::ADR_PREFAULT, 32'h64);
        apply(16'h0, 3'h7, 3'h1, 1'b0);
        wait_evt();
        for (int i = 0; i < 3; i++) begin
            chk_reg("counter", cbo_pkg::ADR_CNT_START + 8'(4 * i), 32'h1);
        end
        // one clear empties all three counters
        wr(cbo_pkg::ADR_CTRL, 32'h105);
        for (int i = 0; i < 3; i++) begin
            chk_reg("counter cleared", cbo_pkg::ADR_CNT_START + 8'(4 * i), 32'h0);
        end
        wr(cbo_pkg::ADR_SET0 + 8'h4, 32'h0014_00c8);
        @(posedge clk);
        set_select <= 3'h1;
        apply(16'h0096, 3'h7, 3'h1, 1'b0);
        idle(3);
        outs("set1 higher threshold", 3'b000);
        chk_reg("status", cbo_pkg::ADR_STATUS, 32'h0000_0340);
        @(posedge clk);
        set_select <= 3'h0;
        wait_evt();
        outs("set0 live", 3'b011);
        apply(16'h0, 3'h7, 3'h1, 1'b0);
        wait_evt();
        for (int m = 1; m <= 2; m++) begin
            wr(cbo_pkg::ADR_SET0, 32'h0014_0078 | (32'(m) << 13));
            apply(16'h00f0, 3'h2, 3'h1, 1'b0);
            wait_evt();
            outs("delayed start", 3'b001);
            t0 = cyc;
            wait_evt();
            outs("delayed trip", 3'b011);
            check("trip delay", {31'h0, (m == 1) ? (cyc - t0 >= 150) : (cyc - t0 < 150)},
                32'h1);
            apply(16'h0, 3'h7, 3'h1, 1'b0);
            wait_evt();
        end
        @(posedge clk);
        force_enable <= 1'b1;
        for (int f = 2; f <= 4; f++) begin
            wr(cbo_pkg::ADR_CTRL, 32'h1 | (32'(f) << 2));
            idle(2);
            outs("forced status", fx[f - 2]);
        end
        @(posedge clk);
        force_enable <= 1'b0;
        idle(2);
        outs("forcing disabled", 3'b000);
        rd(cbo_pkg::ADR_STAMP, d0);
        repeat (98) @(posedge clk);
        rd(cbo_pkg::ADR_STAMP, d1);
        check("stamp step", d1 - d0, 32'd10);
        report_and_stop();
    end
endmodule
